// file: design/core_debug_scan.sv
`timescale 1ns/100ps
`include "core_debug_scan_consts.svh"
// Summary of operation
// RQ1 - Capture program counter at entry, points at latch
// RQ2 - Exit with no-op resumes at copy plus four
// RQ3 - Low capture half latches instruction result
// RQ4 - High half holds load-with-update address
// RQ5 - Substitute flag feeds low half as operand
// RQ6 - Capture halves undefined without write-back
// RQ7 - Machine state image readable and writable
// RQ8 - Watchpoints only in internal or external halt
// RQ9 - Six outputs: four instruction, two data compares
// RQ10 - No enable; silent during debug session
// RQ11 - Halt event allow bit ignored for watchpoints
// RQ12 - Watchpoint asserts cycle after match
// RQ13 - Disabled data compare flags loads and stores
// RQ14 - Debugger enables unit before any operation
// RQ15 - Request plus keep-awake halts core in debug
// RQ16 - Status out on IR shift, chain on DR
// RQ17 - First halt control write sets only mode
// RQ18 - Debugger should disable translation during debug
// RQ19 - Debugger should clear interrupt allows in image
// RQ20 - Single step by go without exit
// RQ21 - Resume: clear request, go-exit, then wake
// RQ22 - Leave debug: clear controls, go-exit, wake
module core_debug_scan
  import core_debug_scan_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Test access pins, asynchronous to clk_sys
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdoEn,
  input  wire logic        debug_unit_enable_in,
  // Core side
  input  wire logic        coreHalted,
  input  wire logic        coreFault,
  input  wire logic [31:0] corePc,
  input  wire logic [31:0] coreInstr,
  input  wire logic [31:0] coreMsr,
  input  wire core_ret_s   coreRet,
  input  wire logic [3:0]  instrAddrMatch,
  input  wire logic [1:0]  dataAddrMatch,
  input  wire logic        dataIsStore,
  output logic             haltReq,
  output logic             stepGo,
  output logic             exitGo,
  output core_exec_s       execCmd,
  output logic             instrTranslateOff,
  output logic             dataTranslateOff,
  output logic [5:0]       watch_flag_out
);

  // One-hot test access controller states
  typedef enum logic [15:0] {
    RESET  = 16'h0001, IDLE   = 16'h0002, SELDR  = 16'h0004, CAPDR  = 16'h0008,
    SHDR   = 16'h0010, EX1DR  = 16'h0020, PAUSDR = 16'h0040, EX2DR  = 16'h0080,
    UPDR   = 16'h0100, SELIR  = 16'h0200, CAPIR  = 16'h0400, SHIR   = 16'h0800,
    EX1IR  = 16'h1000, PAUSIR = 16'h2000, EX2IR  = 16'h4000, UPIR   = 16'h8000
  } tap_e;

  // Standard next state on a test clock rise
  function automatic tap_e tapNext(input tap_e s, input logic m);
    case (s)
      RESET:   tapNext = m ? RESET : IDLE;
      IDLE:    tapNext = m ? SELDR : IDLE;
      SELDR:   tapNext = m ? SELIR : CAPDR;
      CAPDR:   tapNext = m ? EX1DR : SHDR;
      SHDR:    tapNext = m ? EX1DR : SHDR;
      EX1DR:   tapNext = m ? UPDR  : PAUSDR;
      PAUSDR:  tapNext = m ? EX2DR : PAUSDR;
      EX2DR:   tapNext = m ? UPDR  : SHDR;
      UPDR:    tapNext = m ? SELDR : IDLE;
      SELIR:   tapNext = m ? RESET : CAPIR;
      CAPIR:   tapNext = m ? EX1IR : SHIR;
      SHIR:    tapNext = m ? EX1IR : SHIR;
      EX1IR:   tapNext = m ? UPIR  : PAUSIR;
      PAUSIR:  tapNext = m ? EX2IR : PAUSIR;
      EX2IR:   tapNext = m ? UPIR  : SHIR;
      UPIR:    tapNext = m ? SELDR : IDLE;
      default: tapNext = RESET;
    endcase
  endfunction : tapNext

  // Data compare qualified by enabled access types
  function automatic logic dacHit(input logic m, input logic ld, input logic st,
                                  input logic isSt);
    // Fully disabled compare flags both kinds of access
    dacHit = m & ((!ld && !st) | (isSt ? st : ld));
  endfunction : dacHit

  // Pin synchronisers; stage 0 is read only by stage 1
  logic [2:0]            tckSync;       // Extra stage for edge finding
  logic [1:0]            tmsSync;
  logic [1:0]            tdiSync;
  logic [1:0]            enSync;
  logic                  tckRise;
  logic                  tckFall;
  logic                  unitOn;        // Debug unit enabled

  tap_e                  tapState;      // Controller state
  logic [`CMD_W-1:0]     irShift;       // Command shifter
  logic [`CMD_W-1:0]     cmd;           // Active command
  logic [`CHAIN_W-1:0]   drShift;       // Data shifter, shared by all selects
  logic [`WORD_W-1:0]    ctrlWord;      // Debug control word
  logic [`WORD_W-1:0]    haltCtl;       // Halt control 0
  logic [5:0]            haltStat;      // Sticky halt events
  logic [`WORD_W-1:0]    ctlWord;       // Chain control word
  logic [`WORD_W-1:0]    instrLatch;
  logic [`WORD_W-1:0]    pcCopy;
  logic [`WORD_W-1:0]    msrImage;
  logic [`WORD_W-1:0]    wbLow;
  logic [`WORD_W-1:0]    wbHigh;
  logic                  haltedQ;       // Core halted, previous cycle
  logic                  updDr;         // Update-DR taken this cycle
  logic                  updIr;
  logic                  capDr;
  logic                  capIr;
  logic [`CMD_SEL_W-1:0] sel;
  logic                  wr;
  logic                  modeOn;
  logic [5:0]            hits;          // Raw compare events, qualified
  logic [5:0]            enHits;        // Events enabled to set status
  logic [`WORD_W-1:0]    topWord;       // Last 32 bits shifted in

  // Test clock edges, found one stage past the synchroniser
  assign tckRise = tckSync[1] & ~tckSync[2];
  assign tckFall = ~tckSync[1] & tckSync[2];
  assign unitOn  = enSync[1];
  assign sel     = cmd[`CMD_SEL_W-1:0];
  assign wr      = ~cmd[`CMD_READ];
  // Capture and update act on the rise that leaves their state
  assign updDr   = tckRise & (tapState == UPDR);
  assign updIr   = tckRise & (tapState == UPIR);
  assign capDr   = tckRise & (tapState == CAPDR);
  assign capIr   = tckRise & (tapState == CAPIR);
  assign topWord = drShift[`CHAIN_W-1 -: `WORD_W];
  assign modeOn  = haltCtl[`HC_EDM] | haltCtl[`HC_IDM];  // RQ8 RQ11

  // Compare events: instruction ones raw, data ones access-qualified
  assign hits = {dacHit(dataAddrMatch[1], haltCtl[`HC_DAC2_LD], haltCtl[`HC_DAC2_ST],
                        dataIsStore),
                 dacHit(dataAddrMatch[0], haltCtl[`HC_DAC1_LD], haltCtl[`HC_DAC1_ST],
                        dataIsStore),
                 instrAddrMatch};  // RQ9 RQ13
  assign enHits = {dataAddrMatch[1] & (haltCtl[`HC_DAC2_LD] | haltCtl[`HC_DAC2_ST]),
                   dataAddrMatch[0] & (haltCtl[`HC_DAC1_LD] | haltCtl[`HC_DAC1_ST]),
                   instrAddrMatch & haltCtl[`HC_IAC_LO +: 4]} & hits;

  // Two flip-flop synchronisers on every pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tckSync <= 3'h0;
      tmsSync <= 2'h3;
      tdiSync <= 2'h0;
      enSync  <= 2'h0;
    end else begin
      tckSync <= {tckSync[1:0], tck};
      tmsSync <= {tmsSync[0], tms};
      tdiSync <= {tdiSync[0], tdi};
      enSync  <= {enSync[0], debug_unit_enable_in};
    end
  end

  // Controller; held in reset while the unit is disabled
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tapState <= RESET;
    end else if (!unitOn) begin
      tapState <= RESET;  // RQ14
    end else if (tckRise) begin
      tapState <= tapNext(tapState, tmsSync[1]);
    end
  end

  // Command shifter: status word goes out while command comes in
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irShift <= '0;
      cmd     <= {3'h0, `SEL_NONE};
    end else if (tapState == RESET) begin
      cmd     <= {3'h0, `SEL_NONE};
    end else if (capIr) begin
      // Status snapshot on capture
      irShift <= '0;
      irShift[`SW_HALTED]  <= coreHalted;
      irShift[`SW_FAULT]   <= coreFault;
      irShift[`SW_WAKE]    <= ctrlWord[`CW_WAKE];
      irShift[`SW_ENABLED] <= unitOn;  // RQ16
    end else if (tckRise && tapState == SHIR) begin
      irShift <= {tdiSync[1], irShift[`CMD_W-1:1]};
    end else if (updIr) begin
      cmd <= irShift;
    end
  end

  // Data shifter; narrow registers load low and end up at the top
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      drShift <= '0;
    end else if (capDr) begin
      drShift <= '0;
      case (sel)
        `SEL_CHAIN:    drShift <= {ctlWord, instrLatch, pcCopy,
                                   msrImage, wbHigh, wbLow};  // RQ7 RQ16
        `SEL_CTRL:     drShift[`WORD_W-1:0] <= ctrlWord;
        `SEL_HALTCTL:  drShift[`WORD_W-1:0] <= haltCtl;
        `SEL_HALTSTAT: drShift[5:0] <= haltStat;
        default:       drShift[0] <= 1'b0;  // Bypass bit
      endcase
    end else if (tckRise && tapState == SHDR) begin
      drShift <= {tdiSync[1], drShift[`CHAIN_W-1:1]};
    end
  end

  // Output pin changes on the test clock fall
  // Falling-edge launch gives the probe half a period of setup
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tdo   <= 1'b0;
      tdoEn <= 1'b0;
    end else if (tckFall) begin
      tdoEn <= (tapState == SHDR) | (tapState == SHIR);
      tdo   <= (tapState == SHIR) ? irShift[0] : drShift[0];
    end
  end

  // Debug control word and the halt request it drives
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrlWord <= '0;
      haltReq  <= 1'b0;
      instrTranslateOff <= 1'b0;
      dataTranslateOff  <= 1'b0;
    end else begin
      if (updDr && wr && sel == `SEL_CTRL) begin
        ctrlWord <= topWord;
      end
      // Halt only with both request and keep-awake set
      haltReq <= ctrlWord[`CW_REQ] & ctrlWord[`CW_WAKE] & unitOn;  // RQ15
      instrTranslateOff <= ctrlWord[`CW_ITOFF];
      dataTranslateOff  <= ctrlWord[`CW_DTOFF];
    end
  end

  // Halt control; while external mode is clear only that bit lands
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      haltCtl <= '0;
    end else if (updDr && wr && sel == `SEL_HALTCTL) begin
      if (!haltCtl[`HC_EDM]) begin
        haltCtl[`HC_EDM] <= topWord[`HC_EDM];  // RQ17
      end else begin
        haltCtl <= topWord;
      end
    end
  end

  // Sticky halt events; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      haltStat <= '0;
    end else begin
      if (updDr && wr && sel == `SEL_HALTSTAT) begin
        haltStat <= (haltStat & ~topWord[5:0]) | enHits;
      end else begin
        haltStat <= haltStat | enHits;
      end
    end
  end

  // Watchpoints: one cycle after the compare, muted while halted
  // Muting keeps debugger-run instructions from raising flags
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      watch_flag_out <= '0;
    end else begin
      watch_flag_out <= (modeOn && !coreHalted) ? hits : 6'h00;  // RQ8 RQ10 RQ12
    end
  end

  // Chain contents: entry capture, scan writes, instruction results
  // Entry capture outranks a scan write landing in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      haltedQ    <= 1'b0;
      ctlWord    <= '0;
      instrLatch <= `NOP_WORD;
      pcCopy     <= '0;
      msrImage   <= '0;
      wbLow      <= '0;
      wbHigh     <= '0;
    end else begin
      haltedQ <= coreHalted;
      if (coreHalted && !haltedQ) begin
        // Entry: counter points at the latched instruction
        pcCopy     <= corePc;     // RQ1
        instrLatch <= coreInstr;  // RQ1
        msrImage   <= coreMsr;    // RQ7
      end else if (updDr && wr && sel == `SEL_CHAIN) begin
        {ctlWord, instrLatch, pcCopy, msrImage, wbHigh, wbLow} <= drShift;  // RQ7
      end else if (coreRet.valid) begin
        // Results without write-back leave the low half stale; a load-with-update still sets the high half
        if (coreRet.writesBack) begin
          wbLow <= coreRet.result;  // RQ3 RQ6
        end
        if (coreRet.loadUpdate) begin
          wbHigh <= coreRet.effAddr;  // RQ4
        end
      end
    end
  end

  // Go commands fire on the chain update that carries them
  // A running core cannot take a go, so it is dropped then
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stepGo  <= 1'b0;
      exitGo  <= 1'b0;
      execCmd <= '0;
    end else begin
      stepGo <= 1'b0;
      exitGo <= 1'b0;
      if (updDr && wr && sel == `SEL_CHAIN && cmd[`CMD_GO] && coreHalted) begin
        stepGo <= ~cmd[`CMD_EXIT];  // RQ20
        exitGo <= cmd[`CMD_EXIT];   // RQ21 RQ22
        execCmd.instr <= drShift[`CHAIN_W-`WORD_W-1 -: `WORD_W];
        execCmd.machine_state_image   <= drShift[3*`WORD_W-1 -: `WORD_W];
        // Exit on a no-op: run it, then fetch from copy plus four
        execCmd.pc <= (cmd[`CMD_EXIT] &&
                       drShift[`CHAIN_W-`WORD_W-1 -: `WORD_W] == `NOP_WORD) ?
                      drShift[4*`WORD_W-1 -: `WORD_W] + `PC_STEP :
                      drShift[4*`WORD_W-1 -: `WORD_W];  // RQ2
        // Substitute low half as source operand
        execCmd.subst   <= drShift[`CHAIN_W-`WORD_W+`CTL_SUBST];  // RQ5
        execCmd.operand <= drShift[`WORD_W-1:0];                  // RQ5
      end
    end
  end

endmodule : core_debug_scan

// file: inc/core_debug_scan_consts.svh
`ifndef CORE_DEBUG_SCAN_CONSTS_SVH
`define CORE_DEBUG_SCAN_CONSTS_SVH
// Command word layout shifted in during the instruction-register shift
`define CMD_W        10
`define CMD_READ     9
`define CMD_GO       8
`define CMD_EXIT     7
`define CMD_SEL_W    7
// Register select codes
`define SEL_NONE     7'h7F
`define SEL_CHAIN    7'h10
`define SEL_CTRL     7'h12
`define SEL_HALTCTL  7'h20
`define SEL_HALTSTAT 7'h30
// Word and chain widths
`define WORD_W       32
`define CHAIN_W      192
// Control word bits
`define CW_REQ       0
`define CW_WAKE      1
`define CW_ITOFF     2
`define CW_DTOFF     3
// Status word bits
`define SW_HALTED    0
`define SW_FAULT     1
`define SW_WAKE      2
`define SW_ENABLED   3
// Halt control bits
`define HC_EDM       31
`define HC_IDM       30
`define HC_IAC_LO    20
`define HC_DAC1_LD   19
`define HC_DAC1_ST   18
`define HC_DAC2_LD   17
`define HC_DAC2_ST   16
// Chain control word: operand substitute bit
`define CTL_SUBST    0
// No-operation encoding and resume step
`define NOP_WORD     32'h60000000
`define PC_STEP      32'h00000004
`endif

// file: inc/core_debug_scan_pkg.sv
package core_debug_scan_pkg;
  // Result reported by the core for each instruction run in debug
  typedef struct packed {
    logic        valid;
    logic        writesBack;
    logic        loadUpdate;
    logic [31:0] result;
    logic [31:0] effAddr;
  } core_ret_s;
  // Everything the core needs to run one debug instruction
  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] pc;
    logic [31:0] machine_state_image;
    logic        subst;
    logic [31:0] operand;
  } core_exec_s;
endpackage : core_debug_scan_pkg

// file: test/core_debug_scan_checker.sv
`timescale 1ns/100ps
// Port-level watch over watchpoints, go pulses and halt request
module core_debug_scan_checker
  import core_debug_scan_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       debug_unit_enable_in,
  input wire logic       coreHalted,
  input wire logic [3:0] instrAddrMatch,
  input wire logic [1:0] dataAddrMatch,
  input wire logic       haltReq,
  input wire logic       stepGo,
  input wire logic       exitGo,
  input wire core_exec_s execCmd,
  input wire logic [5:0] watch_flag_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Either go pulse
  sequence s_go;
    stepGo || exitGo;
  endsequence
  // Any watch output raised
  sequence s_flag;
    watch_flag_out != 6'h00;
  endsequence
  // Instruction flags only one cycle after their own compare
  property p_watch_instr;
    s_flag |-> (watch_flag_out[3:0] & ~$past(instrAddrMatch)) == 4'h0;
  endproperty
  a_watch_instr: assert property (p_watch_instr)
    else $error("instruction watch without match");
  // Data flags sit in the top two bits
  property p_watch_data;
    s_flag |-> (watch_flag_out[5:4] & ~$past(dataAddrMatch)) == 2'h0;
  endproperty
  a_watch_data: assert property (p_watch_data)
    else $error("data watch without match");
  // Silent while a debug session runs
  property p_watch_quiet;
    $past(coreHalted) |-> watch_flag_out == 6'h00;
  endproperty
  a_watch_quiet: assert property (p_watch_quiet)
    else $error("watch during debug session");
  property p_go_excl;
    s_go |-> !(stepGo && exitGo);
  endproperty
  a_go_excl: assert property (p_go_excl)
    else $error("step and exit together");
  // Go is a single-cycle pulse
  property p_go_pulse;
    s_go |=> !stepGo && !exitGo;
  endproperty
  a_go_pulse: assert property (p_go_pulse)
    else $error("go longer than one cycle");
  // Go only reaches a halted core
  property p_go_halted;
    s_go |-> $past(coreHalted);
  endproperty
  a_go_halted: assert property (p_go_halted)
    else $error("go while core running");
  // Command stands until a go carries it
  property p_exec_hold;
    $changed(execCmd) |-> ##[0:1] s_go;
  endproperty
  a_exec_hold: assert property (p_exec_hold)
    else $error("command changed without go");
  // No halt request once the unit is disabled
  property p_halt_enable;
    !debug_unit_enable_in [*4] |-> !haltReq;
  endproperty
  a_halt_enable: assert property (p_halt_enable)
    else $error("halt request while disabled");
endmodule : core_debug_scan_checker

bind core_debug_scan core_debug_scan_checker core_debug_scan_checker_inst (
  .clk_sys(clk_sys), .rstn(rstn), .debug_unit_enable_in(debug_unit_enable_in),
  .coreHalted(coreHalted), .instrAddrMatch(instrAddrMatch), .dataAddrMatch(dataAddrMatch),
  .haltReq(haltReq), .stepGo(stepGo), .exitGo(exitGo), .execCmd(execCmd),
  .watch_flag_out(watch_flag_out)
);

// file: test/debug_probe_model.sv
`timescale 1ns/100ps
// Debugger model; test clock stands low between frames
module debug_probe_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock period; the port value is taken on the rise
  task automatic tick(input logic tmsV, input logic tdiV, output logic tdoV);
    tms = tmsV;
    tdi = tdiV;
    #80;
    tck = 1'b1;
    tdoV = tdo;
    #80;
    tck = 1'b0;
  endtask : tick
  // Command frame then data frame, both LSB first, back to idle
  task automatic scan(input logic [9:0] cmd, input int n, input logic [191:0] din,
                      output logic [9:0] irOut, output logic [191:0] dOut);
    logic b;
    int   i;
    irOut = '0;
    dOut = '0;
    #1.3;
    for (i = 0; i < 5; i++) tick(i == 1 || i == 2, 1'b0, b);
    for (i = 0; i < 10; i++) begin
      tick(i == 9, cmd[i], b);
      irOut[i] = b;
    end
    tick(1'b1, 1'b0, b);
    for (i = 0; i < 3; i++) tick(i == 0, 1'b0, b);
    for (i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dOut[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    // Released line must not keep showing the last bit
    tdi = ~tdi;
  endtask : scan
endmodule : debug_probe_model

// file: test/core_debug_scan_bench.sv
`timescale 1ns/100ps
`include "core_debug_scan_consts.svh"
module core_debug_scan_bench
  import core_debug_scan_pkg::*;
;
  logic         clk_sys;
  logic         rstn = 1'b0;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         tdo;
  logic         tdoEn;
  logic         debug_unit_enable_in = 1'b0;
  logic         coreHalted = 1'b0;
  logic [31:0]  corePc = 32'h0;
  logic [31:0]  coreInstr = 32'h0;
  logic [31:0]  coreMsr = 32'h0;
  core_ret_s    coreRet = '0;
  logic [3:0]   instrAddrMatch = 4'h0;
  logic [1:0]   dataAddrMatch = 2'h0;
  logic         dataIsStore = 1'b0;
  logic         coreFault = 1'b0;
  logic         haltReq;
  logic         stepGo;
  logic         exitGo;
  core_exec_s   execCmd;
  logic         instrTranslateOff;
  logic         dataTranslateOff;
  logic [5:0]   watch_flag_out;
  int           nErrors = 0;
  int           checkCount = 0;
  int           nStep = 0;
  int           nExit = 0;
  int           nEn = 0;   // Clock cycles with the output enable high
  core_exec_s   goCmd;     // Command seen with the last go
  logic [9:0]   irOut;     // Status shifted out
  logic [191:0] dOut;      // Data shifted out

  core_debug_scan core_debug_scan_inst (
    .clk_sys(clk_sys), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoEn(tdoEn), .debug_unit_enable_in(debug_unit_enable_in), .coreHalted(coreHalted),
    .coreFault(coreFault), .corePc(corePc), .coreInstr(coreInstr), .coreMsr(coreMsr),
    .coreRet(coreRet), .instrAddrMatch(instrAddrMatch), .dataAddrMatch(dataAddrMatch),
    .dataIsStore(dataIsStore), .haltReq(haltReq), .stepGo(stepGo), .exitGo(exitGo),
    .execCmd(execCmd), .instrTranslateOff(instrTranslateOff),
    .dataTranslateOff(dataTranslateOff), .watch_flag_out(watch_flag_out)
  );
  debug_probe_model debug_probe_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // Clock at 4 ns
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Count go pulses; a long pulse shows as an extra count
  always @(posedge clk_sys) begin
    if (stepGo) nStep <= nStep + 1;
    if (exitGo) nExit <= nExit + 1;
    if (stepGo || exitGo) goCmd <= execCmd;
    if (tdoEn) nEn <= nEn + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // Whole frame, then let go and status settle
  task automatic frame(input logic [9:0] cmd, input int n, input logic [191:0] din);
    int n0;
    n0 = nEn;
    debug_probe_model_inst.scan(cmd, n, din, irOut, dOut);
    repeat (3) @(posedge clk_sys);
    #1;
    // Enable stands for exactly the shifted bits, 40 clocks each
    check(nEn - n0, (10 + n) * 40);
  endtask : frame
  // One compare cycle, flags judged on the next cycle
  task automatic pulse(input logic [3:0] im, input logic [1:0] dm, input logic st,
                       input logic [5:0] exp);
    @(posedge clk_sys);
    instrAddrMatch <= im;
    dataAddrMatch <= dm;
    dataIsStore <= st;
    @(posedge clk_sys);
    instrAddrMatch <= 4'h0;
    dataAddrMatch <= 2'h0;
    #1 check(watch_flag_out, exp);
  endtask : pulse
  task automatic tWatch();
    int i;
    pulse(4'hF, 2'h3, 1'b0, 6'h00);
    frame({3'b000, `SEL_HALTCTL}, 32, 192'hFFFFFFFF);
    frame({3'b100, `SEL_HALTCTL}, 32, 192'h0);
    check(dOut[31:0], 32'h80000000);
    for (i = 0; i < 4; i++) pulse(4'h1 << i, 2'h0, 1'b0, 6'h01 << i);
    pulse(4'h0, 2'h3, 1'b1, 6'h30);
    pulse(4'h0, 2'h3, 1'b0, 6'h30);
    frame({3'b000, `SEL_HALTCTL}, 32, 192'h800A0000);
    pulse(4'h0, 2'h3, 1'b1, 6'h00);
    pulse(4'h0, 2'h3, 1'b0, 6'h30);
    $display("watchpoint test done");
  endtask : tWatch
  task automatic tEnter();
    frame({3'b000, `SEL_CTRL}, 32, 192'hF);
    check(haltReq, 1'b1);
    check({instrTranslateOff, dataTranslateOff}, 2'b11);
    @(posedge clk_sys);
    corePc <= 32'h10000040;
    coreInstr <= 32'h12345678;
    coreMsr <= 32'h00029200;
    coreHalted <= 1'b1;
    pulse(4'hF, 2'h3, 1'b0, 6'h00);
    @(posedge clk_sys);
    coreRet <= '{1'b1, 1'b1, 1'b1, 32'hA5A50001, 32'h00002004};
    @(posedge clk_sys);
    coreRet.valid <= 1'b0;
    frame({3'b100, `SEL_CHAIN}, 192, 192'h0);
    check(irOut[3:0], 4'hD);
    check(dOut[31:0], 32'hA5A50001);
    check(dOut[63:32], 32'h00002004);
    check(dOut[95:64], 32'h00029200);
    check(dOut[127:96], 32'h10000040);
    check(dOut[159:128], 32'h12345678);
    $display("entry test done");
  endtask : tEnter
  task automatic tStep();
    frame({3'b010, `SEL_CHAIN}, 192,
          {32'h1, 32'h60210000, 32'h10000040, 32'h00029200, 32'h0, 32'hCAFE0123});
    check(nStep, 1);
    check(nExit, 0);
    check(goCmd.subst, 1'b1);
    check(goCmd.operand, 32'hCAFE0123);
    check(goCmd.machine_state_image, 32'h00029200);
    frame({3'b000, `SEL_NONE}, 1, 192'h0);
    check(irOut[1:0], 2'b01);
    // A reported fault must show in the status word
    @(posedge clk_sys);
    coreFault <= 1'b1;
    frame({3'b000, `SEL_NONE}, 1, 192'h0);
    check(irOut[1:0], 2'b11);
    @(posedge clk_sys);
    coreFault <= 1'b0;
    $display("step test done");
  endtask : tStep
  task automatic tExit();
    frame({3'b000, `SEL_CTRL}, 32, 192'h2);
    check({haltReq, instrTranslateOff, dataTranslateOff}, 3'b000);
    frame({3'b011, `SEL_CHAIN}, 192, {32'h0, `NOP_WORD, 32'h1000003C, 32'h00029200, 64'h0});
    check(nExit, 1);
    check(goCmd.pc, 32'h10000040);
    check(goCmd.instr, `NOP_WORD);
    @(posedge clk_sys);
    coreHalted <= 1'b0;
    $display("exit test done");
  endtask : tExit
  task automatic tDisable();
    // Leaving external mode: halt control cleared in full, flags stop
    frame({3'b000, `SEL_HALTCTL}, 32, 192'h0);
    pulse(4'hF, 2'h3, 1'b0, 6'h00);
    frame({3'b000, `SEL_CTRL}, 32, 192'h3);
    check(haltReq, 1'b1);
    @(posedge clk_sys);
    debug_unit_enable_in <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 check(haltReq, 1'b0);
    $display("disable test done");
  endtask : tDisable
  task automatic results();
    $display("mismatches %0d comparisons %0d", nErrors, checkCount);
    if (nErrors == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // Main sequence; unit enabled during reset, before any frame
  initial begin
    repeat (5) @(posedge clk_sys);
    debug_unit_enable_in <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    tWatch();
    tEnter();
    tStep();
    tExit();
    tDisable();
    results();
  end
  // Hang guard, about twice the expected run
  initial begin
    #300000;
    nErrors++;
    results();
  end
endmodule : core_debug_scan_bench
